// ### rtl/ppic_top.sv
`timescale 1ns/100ps
module ppic_top #(
   parameter int MS_CYCLES = ppic_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic                     SYS_CLK_IN,
   input  wire logic                     RESET_IN,
   // serial bus
   input  wire logic                     SCL_IN,
   input  wire logic                     SDA_IN,
   output logic                          SDA_OUT,
   output logic                          SDA_OE_OUT,
   // supply and sequencing inputs
   input  wire logic                     SUPPLY_OK_IN,
   input  wire logic                     ENABLE_IN,
   input  wire logic                     SUPPLY_LOW_IN,
   input  wire logic                     BOOST_RISE_IN,
   // analogue controls
   output ppic_pkg::ppic_rail_cfg_t      CFG_OUT,
   output ppic_pkg::ppic_rail_en_t       RAIL_EN_OUT,
   output logic                          RESET_N_OUT
);

   localparam int TW = $clog2(MS_CYCLES + 1);

   if (MS_CYCLES < 2) begin : g_chk
      $error("MS_CYCLES must be at least 2");
   end

   // serial state
   ppic_pkg::ppic_i2c_state_t st_r, st_nxt;
   logic [2:0]   cnt_r, cnt_nxt;
   logic [7:0]   sh_r, sh_nxt;
   logic [7:0]   idx_r, idx_nxt;
   logic         full_r, full_nxt;
   logic         rw_r, rw_nxt;
   logic         cal_sel_r, cal_sel_nxt;
   logic         mack_r, mack_nxt;
   logic         oe_r, oe_nxt;
   logic         scl_q_r, sda_q_r;
   logic         wr_main, wr_cal;
   // register bank
   logic [7:0]   work_r [ppic_pkg::BANK_DEPTH];
   logic [7:0]   work_nxt [ppic_pkg::BANK_DEPTH];
   logic [7:0]   nv_r [ppic_pkg::BANK_DEPTH];
   logic [7:0]   nv_nxt [ppic_pkg::BANK_DEPTH];
   logic [7:0]   ctrl_r, ctrl_nxt;
   logic [6:0]   cal_r, cal_nxt;
   logic [6:0]   cal_nv_r, cal_nv_nxt;
   ppic_pkg::ppic_rail_cfg_t cfg_r, cfg_nxt;
   // sequencer
   ppic_pkg::ppic_seq_state_t seq_r, seq_nxt;
   logic [TW-1:0] tick_r, tick_nxt;
   logic [7:0]   ms_up_r, ms_up_nxt;
   logic [7:0]   ms_bst_r, ms_bst_nxt;
   logic         bst_seen_r, bst_seen_nxt;
   logic         rst_n_r, rst_n_nxt;
   logic         seq_load;
   ppic_pkg::ppic_rail_en_t en_r, en_nxt;

   wire scl_rise = SCL_IN & ~scl_q_r;
   wire scl_fall = ~SCL_IN & scl_q_r;
   wire start    = scl_q_r & SCL_IN & sda_q_r & ~SDA_IN;
   wire stop     = scl_q_r & SCL_IN & ~sda_q_r & SDA_IN;

   // indices that hold a working register
   function automatic logic is_mapped(input logic [7:0] idx);
      logic m;
      m = 1'b0;
      if (idx == ppic_pkg::IDX_HALF_LVL || idx == ppic_pkg::IDX_IO_LVL ||
          idx == ppic_pkg::IDX_LDO_LVL  || idx == ppic_pkg::IDX_COMMON_ELECTRODE_LEVEL_LVL ||
          idx == ppic_pkg::IDX_RST_TH   || idx == ppic_pkg::IDX_GAMMA_UP ||
          idx == ppic_pkg::IDX_GAMMA_LO || idx == ppic_pkg::IDX_CORE_CFG ||
          idx == ppic_pkg::IDX_IO_CFG   || idx == ppic_pkg::IDX_LDO_CFG ||
          idx == ppic_pkg::IDX_RST_DLY  || idx == ppic_pkg::IDX_COMMON_ELECTRODE_LEVEL_DLY) begin
         m = 1'b1;
      end
      return m;
   endfunction : is_mapped

   // value after reset of each index
   function automatic logic [7:0] reg_default(input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         ppic_pkg::IDX_HALF_LVL: v = ppic_pkg::RST_HALF_LVL;
         ppic_pkg::IDX_IO_LVL:   v = ppic_pkg::RST_IO_LVL;
         ppic_pkg::IDX_LDO_LVL:  v = ppic_pkg::RST_LDO_LVL;
         ppic_pkg::IDX_COMMON_ELECTRODE_LEVEL_LVL: v = ppic_pkg::RST_COMMON_ELECTRODE_LEVEL_LVL;
         ppic_pkg::IDX_RST_TH:   v = ppic_pkg::RST_RST_TH;
         ppic_pkg::IDX_GAMMA_UP: v = ppic_pkg::RST_GAMMA_UP;
         ppic_pkg::IDX_GAMMA_LO: v = ppic_pkg::RST_GAMMA_LO;
         ppic_pkg::IDX_CORE_CFG: v = ppic_pkg::RST_CORE_CFG;
         ppic_pkg::IDX_IO_CFG:   v = ppic_pkg::RST_IO_CFG;
         ppic_pkg::IDX_LDO_CFG:  v = ppic_pkg::RST_LDO_CFG;
         ppic_pkg::IDX_RST_DLY:  v = ppic_pkg::RST_RST_DLY;
         ppic_pkg::IDX_COMMON_ELECTRODE_LEVEL_DLY: v = ppic_pkg::RST_COMMON_ELECTRODE_LEVEL_DLY;
         default:                v = 8'h00;
      endcase
      return v;
   endfunction : reg_default

   // byte returned for a read at an index
   function automatic logic [7:0] read_byte(input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (cal_sel_r) begin
         v = {cal_r, 1'b0};
      end else if (idx == ppic_pkg::IDX_CTRL) begin
         v = ctrl_r;
      end else if (is_mapped(idx)) begin
         v = ctrl_r[ppic_pkg::CTRL_NVSEL_BIT] ? nv_r[idx[4:0]]
                                              : work_r[idx[4:0]];
      end
      return v;
   endfunction : read_byte

   // milliseconds for a delay field at a step size
   function automatic logic [7:0] delay_ms(input logic [4:0] f, input logic [7:0] step);
      logic [12:0] p;
      p = {8'h00, f} * {5'h00, step};
      return p[7:0];
   endfunction : delay_ms

   // serial target next state
   always_comb begin
      st_nxt      = st_r;
      cnt_nxt     = cnt_r;
      sh_nxt      = sh_r;
      idx_nxt     = idx_r;
      full_nxt    = full_r;
      rw_nxt      = rw_r;
      cal_sel_nxt = cal_sel_r;
      mack_nxt    = mack_r;
      oe_nxt      = oe_r;
      wr_main     = 1'b0;
      wr_cal      = 1'b0;
      if (start) begin
         st_nxt   = ppic_pkg::ST_ADDR;
         cnt_nxt  = 3'h0;
         full_nxt = 1'b0;
         oe_nxt   = 1'b0;
      end else if (stop) begin
         st_nxt = ppic_pkg::ST_IDLE;
         oe_nxt = 1'b0;
      end else begin
         unique case (st_r)
            ppic_pkg::ST_IDLE: begin
               oe_nxt = 1'b0;
            end
            ppic_pkg::ST_ADDR, ppic_pkg::ST_INDEX, ppic_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  sh_nxt   = {sh_r[6:0], SDA_IN};
                  cnt_nxt  = cnt_r + 3'h1;
                  full_nxt = (cnt_r == 3'h7);
               end else if (scl_fall && full_r) begin
                  full_nxt = 1'b0;
                  oe_nxt   = 1'b1;                                  // ack low
                  if (st_r == ppic_pkg::ST_ADDR) begin
                     if (sh_r[7:1] == ppic_pkg::MAIN_ADDR ||
                         sh_r[7:1] == ppic_pkg::CAL_ADDR) begin
                        rw_nxt      = sh_r[0];
                        cal_sel_nxt = (sh_r[7:1] == ppic_pkg::CAL_ADDR);
                        st_nxt      = ppic_pkg::ST_ADDR_ACK;
                     end else begin
                        oe_nxt = 1'b0;
                        st_nxt = ppic_pkg::ST_IDLE;
                     end
                  end else if (st_r == ppic_pkg::ST_INDEX) begin
                     idx_nxt = sh_r;
                     st_nxt  = ppic_pkg::ST_INDEX_ACK;
                  end else begin
                     wr_main = ~cal_sel_r;
                     wr_cal  = cal_sel_r;
                     if (!cal_sel_r) begin
                        idx_nxt = idx_r + 8'h01;
                     end
                     st_nxt = ppic_pkg::ST_WDATA_ACK;
                  end
               end
            end
            ppic_pkg::ST_ADDR_ACK, ppic_pkg::ST_INDEX_ACK, ppic_pkg::ST_WDATA_ACK: begin
               if (scl_fall) begin
                  oe_nxt  = 1'b0;
                  cnt_nxt = 3'h0;
                  if (st_r == ppic_pkg::ST_ADDR_ACK && rw_r) begin
                     sh_nxt = read_byte(idx_r);
                     oe_nxt = ~sh_nxt[7];
                     st_nxt = ppic_pkg::ST_RDATA;
                  end else if (st_r == ppic_pkg::ST_ADDR_ACK && !cal_sel_r) begin
                     st_nxt = ppic_pkg::ST_INDEX;
                  end else begin
                     st_nxt = ppic_pkg::ST_WDATA;
                  end
               end
            end
            ppic_pkg::ST_RDATA: begin
               if (scl_fall) begin
                  if (cnt_r == 3'h7) begin
                     oe_nxt = 1'b0;                                  // free line for ack
                     st_nxt = ppic_pkg::ST_RACK;
                  end else begin
                     cnt_nxt = cnt_r + 3'h1;
                     sh_nxt  = {sh_r[6:0], 1'b0};
                     oe_nxt  = ~sh_r[6];
                  end
               end
            end
            ppic_pkg::ST_RACK: begin
               if (scl_rise) begin
                  mack_nxt = ~SDA_IN;
               end else if (scl_fall) begin
                  cnt_nxt = 3'h0;
                  if (mack_r) begin
                     if (!cal_sel_r) begin
                        idx_nxt = idx_r + 8'h01;
                     end
                     sh_nxt = read_byte(idx_r + 8'h01);
                     oe_nxt = ~sh_nxt[7];
                     st_nxt = ppic_pkg::ST_RDATA;
                  end else begin
                     st_nxt = ppic_pkg::ST_IDLE;                     // not ack ends
                  end
               end
            end
         endcase
      end
   end

   // serial target registers
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         st_r      <= ppic_pkg::ST_IDLE;
         cnt_r     <= 3'h0;
         sh_r      <= 8'h00;
         idx_r     <= 8'h00;
         full_r    <= 1'b0;
         rw_r      <= 1'b0;
         cal_sel_r <= 1'b0;
         mack_r    <= 1'b0;
         oe_r      <= 1'b0;
         scl_q_r   <= 1'b1;
         sda_q_r   <= 1'b1;
      end else begin
         st_r      <= st_nxt;
         cnt_r     <= cnt_nxt;
         sh_r      <= sh_nxt;
         idx_r     <= idx_nxt;
         full_r    <= full_nxt;
         rw_r      <= rw_nxt;
         cal_sel_r <= cal_sel_nxt;
         mack_r    <= mack_nxt;
         oe_r      <= oe_nxt;
         scl_q_r   <= SCL_IN;
         sda_q_r   <= SDA_IN;
      end
   end

   // register bank next state
   always_comb begin
      work_nxt   = work_r;
      nv_nxt     = nv_r;
      ctrl_nxt   = ctrl_r;
      cal_nxt    = cal_r;
      cal_nv_nxt = cal_nv_r;
      if (seq_load) begin
         work_nxt = nv_r;
         cal_nxt  = cal_nv_r;
      end else if (wr_main) begin
         if (idx_r == ppic_pkg::IDX_CTRL) begin
            ctrl_nxt = sh_r;
            if (sh_r[ppic_pkg::CTRL_STORE_BIT]) begin
               nv_nxt = work_r;
            end
         end else if (is_mapped(idx_r)) begin
            work_nxt[idx_r[4:0]] = sh_r;
         end
      end else if (wr_cal) begin
         cal_nxt = sh_r[7:1];
         if (!sh_r[ppic_pkg::CAL_DAC_ONLY_BIT]) begin
            cal_nv_nxt = sh_r[7:1];
         end
      end
   end

   // settings bundle from the working registers
   always_comb begin
      cfg_nxt.half_supply_rail     = work_r[ppic_pkg::IDX_HALF_LVL[4:0]][5:0];
      cfg_nxt.io_buck_rail         = work_r[ppic_pkg::IDX_IO_LVL[4:0]][5:0];
      cfg_nxt.linear_regulator     = work_r[ppic_pkg::IDX_LDO_LVL[4:0]][3:0];
      cfg_nxt.common_electrode_out = work_r[ppic_pkg::IDX_COMMON_ELECTRODE_LEVEL_LVL[4:0]];
      cfg_nxt.reset_threshold      = work_r[ppic_pkg::IDX_RST_TH[4:0]][2:0];
      cfg_nxt.gamma_upper_ref      = work_r[ppic_pkg::IDX_GAMMA_UP[4:0]][4:0];
      cfg_nxt.gamma_lower_ref      = work_r[ppic_pkg::IDX_GAMMA_LO[4:0]][4:0];
      // codes pass through unchanged to the switching stages
      cfg_nxt.core_freq = work_r[ppic_pkg::IDX_CORE_CFG[4:0]][ppic_pkg::FREQ_LSB +: 3];
      cfg_nxt.core_slew = work_r[ppic_pkg::IDX_CORE_CFG[4:0]][ppic_pkg::SLEW_LSB +: 2];
      cfg_nxt.io_freq   = work_r[ppic_pkg::IDX_IO_CFG[4:0]][ppic_pkg::FREQ_LSB +: 3];
      cfg_nxt.io_slew   = work_r[ppic_pkg::IDX_IO_CFG[4:0]][ppic_pkg::SLEW_LSB +: 2];
      cfg_nxt.cal_level = cal_r;
   end

   // register bank storage
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         for (int i = 0; i < ppic_pkg::BANK_DEPTH; i++) begin
            work_r[i] <= reg_default(8'(i));
            nv_r[i]   <= reg_default(8'(i));
         end
         ctrl_r   <= ppic_pkg::RST_CTRL;
         cal_r    <= ppic_pkg::RST_CAL;
         cal_nv_r <= ppic_pkg::RST_CAL;
         cfg_r    <= '0;
      end else begin
         work_r   <= work_nxt;
         nv_r     <= nv_nxt;
         ctrl_r   <= ctrl_nxt;
         cal_r    <= cal_nxt;
         cal_nv_r <= cal_nv_nxt;
         cfg_r    <= cfg_nxt;
      end
   end

   // start-up sequencer next state
   always_comb begin
      seq_nxt      = seq_r;
      tick_nxt     = tick_r;
      ms_up_nxt    = ms_up_r;
      ms_bst_nxt   = ms_bst_r;
      bst_seen_nxt = bst_seen_r;
      seq_load     = 1'b0;
      en_nxt       = '0;
      rst_n_nxt    = 1'b0;
      unique case (seq_r)
         ppic_pkg::SEQ_OFF: begin
            tick_nxt     = '0;
            ms_up_nxt    = 8'h00;
            ms_bst_nxt   = 8'h00;
            bst_seen_nxt = 1'b0;
            if (SUPPLY_OK_IN && ENABLE_IN) begin
               seq_nxt = ppic_pkg::SEQ_LOAD;
            end
         end
         ppic_pkg::SEQ_LOAD: begin
            seq_load = 1'b1;
            seq_nxt  = ppic_pkg::SEQ_RUN;
         end
         ppic_pkg::SEQ_RUN: begin
            if (!SUPPLY_OK_IN || !ENABLE_IN) begin
               seq_nxt = ppic_pkg::SEQ_OFF;                          // all off
            end else begin
               // millisecond timebase
               if (tick_r == TW'(MS_CYCLES - 1)) begin
                  tick_nxt = '0;
                  if (ms_up_r != 8'hFF) begin
                     ms_up_nxt = ms_up_r + 8'h01;
                  end
                  if (bst_seen_r && ms_bst_r != 8'hFF) begin
                     ms_bst_nxt = ms_bst_r + 8'h01;
                  end
               end else begin
                  tick_nxt = tick_r + TW'(1);
               end
               if (BOOST_RISE_IN) begin
                  bst_seen_nxt = 1'b1;
               end
               en_nxt.core_buck = ms_up_r >= delay_ms(
                  {3'h0, work_r[ppic_pkg::IDX_CORE_CFG[4:0]][ppic_pkg::DLY_LSB +: 2]},
                  ppic_pkg::BUCK_STEP_MS);
               en_nxt.io_buck = ms_up_r >= delay_ms(
                  {3'h0, work_r[ppic_pkg::IDX_IO_CFG[4:0]][ppic_pkg::DLY_LSB +: 2]},
                  ppic_pkg::BUCK_STEP_MS);
               en_nxt.linear_regulator = ms_up_r >= delay_ms(
                  {3'h0, work_r[ppic_pkg::IDX_LDO_CFG[4:0]][ppic_pkg::DLY_LSB +: 2]},
                  ppic_pkg::BUCK_STEP_MS);
               en_nxt.common_electrode = bst_seen_r && ms_bst_r >= delay_ms(
                  work_r[ppic_pkg::IDX_COMMON_ELECTRODE_LEVEL_DLY[4:0]][4:0], ppic_pkg::COMMON_ELECTRODE_LEVEL_STEP_MS);
               // reset follows the supply level without latching
               rst_n_nxt = !SUPPLY_LOW_IN && ms_up_r >= delay_ms(
                  {1'b0, work_r[ppic_pkg::IDX_RST_DLY[4:0]][3:0]}, ppic_pkg::RST_STEP_MS);
            end
         end
      endcase
   end

   // start-up sequencer registers
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         seq_r      <= ppic_pkg::SEQ_OFF;
         tick_r     <= '0;
         ms_up_r    <= 8'h00;
         ms_bst_r   <= 8'h00;
         bst_seen_r <= 1'b0;
         en_r       <= '0;
         rst_n_r    <= 1'b0;
      end else begin
         seq_r      <= seq_nxt;
         tick_r     <= tick_nxt;
         ms_up_r    <= ms_up_nxt;
         ms_bst_r   <= ms_bst_nxt;
         bst_seen_r <= bst_seen_nxt;
         en_r       <= en_nxt;
         rst_n_r    <= rst_n_nxt;
      end
   end

   // outputs straight from flip-flops, except the data output, which is tied low
   assign SDA_OUT     = 1'b0;   // open drain: only the enable moves
   assign SDA_OE_OUT  = oe_r;
   assign CFG_OUT     = cfg_r;
   assign RAIL_EN_OUT = en_r;
   assign RESET_N_OUT = rst_n_r;

endmodule : ppic_top

// ### include/ppic_pkg.sv
package ppic_pkg;

   // target addresses on the serial bus
   localparam logic [6:0] MAIN_ADDR       = 7'h23;
   localparam logic [6:0] CAL_ADDR        = 7'h4F;

   // register indices
   localparam logic [7:0] IDX_HALF_LVL    = 8'h06;
   localparam logic [7:0] IDX_IO_LVL      = 8'h08;
   localparam logic [7:0] IDX_LDO_LVL     = 8'h09;
   localparam logic [7:0] IDX_COMMON_ELECTRODE_LEVEL_LVL    = 8'h0A;
   localparam logic [7:0] IDX_RST_TH      = 8'h0B;
   localparam logic [7:0] IDX_GAMMA_UP    = 8'h0C;
   localparam logic [7:0] IDX_GAMMA_LO    = 8'h0D;
   localparam logic [7:0] IDX_CORE_CFG    = 8'h12;
   localparam logic [7:0] IDX_IO_CFG      = 8'h13;
   localparam logic [7:0] IDX_LDO_CFG     = 8'h14;
   localparam logic [7:0] IDX_RST_DLY     = 8'h15;
   localparam logic [7:0] IDX_COMMON_ELECTRODE_LEVEL_DLY    = 8'h16;
   localparam logic [7:0] IDX_CTRL        = 8'hFF;

   // values after reset
   localparam logic [7:0] RST_HALF_LVL    = 8'h0A;
   localparam logic [7:0] RST_IO_LVL      = 8'h10;
   localparam logic [7:0] RST_LDO_LVL     = 8'h07;
   localparam logic [7:0] RST_COMMON_ELECTRODE_LEVEL_LVL    = 8'h6E;
   localparam logic [7:0] RST_RST_TH      = 8'h02;
   localparam logic [7:0] RST_GAMMA_UP    = 8'h02;
   localparam logic [7:0] RST_GAMMA_LO    = 8'h06;
   localparam logic [7:0] RST_CORE_CFG    = 8'h45;
   localparam logic [7:0] RST_IO_CFG      = 8'h45;
   localparam logic [7:0] RST_LDO_CFG     = 8'h01;
   localparam logic [7:0] RST_RST_DLY     = 8'h07;
   localparam logic [7:0] RST_COMMON_ELECTRODE_LEVEL_DLY    = 8'h05;
   localparam logic [7:0] RST_CTRL        = 8'h00;
   localparam logic [6:0] RST_CAL         = 7'h40;

   // field positions
   localparam int         CTRL_STORE_BIT  = 7;
   localparam int         CTRL_NVSEL_BIT  = 0;
   localparam int         CAL_DAC_ONLY_BIT = 0;
   localparam int         DLY_LSB         = 0;
   localparam int         FREQ_LSB        = 2;
   localparam int         SLEW_LSB        = 5;

   // bank geometry
   localparam int         BANK_DEPTH      = 32;

   // timebase and delay steps
   localparam int         CLK_FREQ_HZ     = 100_000_000;
   localparam int         TICK_MS         = 1;
   localparam int         MS_CYCLES       = CLK_FREQ_HZ / 1000 * TICK_MS;
   localparam logic [7:0] BUCK_STEP_MS    = 8'h03;
   localparam logic [7:0] RST_STEP_MS     = 8'h05;
   localparam logic [7:0] COMMON_ELECTRODE_LEVEL_STEP_MS    = 8'h05;

   // state machines
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INDEX, ST_INDEX_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
   } ppic_i2c_state_t;

   typedef enum logic [1:0] {SEQ_OFF, SEQ_LOAD, SEQ_RUN} ppic_seq_state_t;

   // settings delivered to the analogue stages
   typedef struct packed {
      logic [5:0] half_supply_rail;
      logic [5:0] io_buck_rail;
      logic [3:0] linear_regulator;
      logic [7:0] common_electrode_out;
      logic [2:0] reset_threshold;
      logic [4:0] gamma_upper_ref;
      logic [4:0] gamma_lower_ref;
      logic [2:0] core_freq;
      logic [1:0] core_slew;
      logic [2:0] io_freq;
      logic [1:0] io_slew;
      logic [6:0] cal_level;
   } ppic_rail_cfg_t;

   // rail enables
   typedef struct packed {
      logic core_buck;
      logic io_buck;
      logic linear_regulator;
      logic common_electrode;
   } ppic_rail_en_t;

endpackage : ppic_pkg

// ### test/ppic_host.sv
`timescale 1ns/100ps
// bus controller model: open drain, wire pulled up, four clocks per third of a bit
module ppic_host (
   input  wire logic clk,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low
);
   initial begin
      scl_out = 1'b1;
      sda_low = 1'b0;
   end
   // third of a bit time
   task automatic hp();
      repeat (4) @(posedge clk);
   endtask : hp
   // start or repeated start, data released first
   task automatic start();
      sda_low <= 1'b0;
      hp();
      scl_out <= 1'b1;
      hp();
      sda_low <= 1'b1;
      hp();
      scl_out <= 1'b0;
      hp();
   endtask : start
   // stop: data rises while clock high
   task automatic stop();
      sda_low <= 1'b1;
      hp();
      scl_out <= 1'b1;
      hp();
      sda_low <= 1'b0;
      hp();
   endtask : stop
   // one bit out while clock low, wire sampled at end of high phase
   task automatic bx(input logic b, output logic r);
      sda_low <= ~b;
      hp();
      scl_out <= 1'b1;
      hp();
      r = sda_in;
      scl_out <= 1'b0;
      hp();
   endtask : bx
   // byte msb first, ninth bit m (1 releases for ack or sends not-ack)
   task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] q,
                     output logic a);
      for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
      bx(m, a);
   endtask : xb
endmodule : ppic_host

// ### test/ppic_top_assertions.sv
`timescale 1ns/100ps
// port level checks of bus drive and rail sequencing
module ppic_top_assertions #(
   parameter int MS_CYCLES = 10
) (
   // clock and reset
   input wire logic                    SYS_CLK_IN,
   input wire logic                    RESET_IN,
   // serial bus
   input wire logic                    SCL_IN,
   input wire logic                    SDA_OUT,
   input wire logic                    SDA_OE_OUT,
   // supply and sequencing
   input wire logic                    SUPPLY_OK_IN,
   input wire logic                    ENABLE_IN,
   input wire logic                    SUPPLY_LOW_IN,
   input wire logic                    RESET_N_OUT,
   input wire ppic_pkg::ppic_rail_en_t RAIL_EN_OUT
);
   logic [15:0] run_r, run_nxt;
   // cycles since supply and enable both came up
   always_comb run_nxt = (SUPPLY_OK_IN && ENABLE_IN) ? run_r + 16'h0001 : 16'h0000;
   always_ff @(posedge SYS_CLK_IN) run_r <= RESET_IN ? 16'h0000 : run_nxt;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RESET_IN);
   rails_off_a: assert property (!SUPPLY_OK_IN |=> RAIL_EN_OUT == '0)
      else $error("rail on without supply");
   gate_off_a: assert property (!ENABLE_IN |=> RAIL_EN_OUT == '0)
      else $error("rail on without enable");
   rst_hold_a: assert property (SUPPLY_LOW_IN |=> !RESET_N_OUT)
      else $error("reset released while supply low");
   rst_lock_a: assert property (!SUPPLY_OK_IN |=> !RESET_N_OUT)
      else $error("reset released under lockout");
   io_delay_a: assert property ($rose(RAIL_EN_OUT.io_buck) |-> run_r >= 3 * MS_CYCLES)
      else $error("io rail started early");
   rst_delay_a: assert property ($rose(RESET_N_OUT) |-> run_r >= 35 * MS_CYCLES)
      else $error("reset released early");
   oe_edge_a: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
      else $error("data drive changed while clock high");
   od_zero_a: assert property (SDA_OE_OUT |-> SDA_OUT == 1'b0)
      else $error("data drive not low");
endmodule : ppic_top_assertions
bind ppic_top ppic_top_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .SYS_CLK_IN    (SYS_CLK_IN),
   .RESET_IN      (RESET_IN),
   .SCL_IN        (SCL_IN),
   .SDA_OUT       (SDA_OUT),
   .SDA_OE_OUT    (SDA_OE_OUT),
   .SUPPLY_OK_IN  (SUPPLY_OK_IN),
   .ENABLE_IN     (ENABLE_IN),
   .SUPPLY_LOW_IN (SUPPLY_LOW_IN),
   .RESET_N_OUT   (RESET_N_OUT),
   .RAIL_EN_OUT   (RAIL_EN_OUT)
);

// ### test/test_ppic_top.sv
`timescale 1ns/100ps
module test_ppic_top;
   logic sys_clk = 1'b0, rst = 1'b1, ok = 1'b0, en = 1'b0, low = 1'b0, boost = 1'b0;
   logic scl, hlow, oe, a, rst_n;
   logic [7:0] q;
   logic [7:0] r[$];
   int n_mismatch = 0, num_checks = 0;
   ppic_pkg::ppic_rail_cfg_t cfg;
   ppic_pkg::ppic_rail_en_t  ren;
   wire sda = ~(hlow | oe); // pull-up unless a party pulls low
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   ppic_host u_host (.clk(sys_clk), .sda_in(sda), .scl_out(scl), .sda_low(hlow));
   ppic_top #(.MS_CYCLES(10)) DUT (.SYS_CLK_IN(sys_clk), .RESET_IN(rst), .SCL_IN(scl),
      .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(oe), .SUPPLY_OK_IN(ok), .ENABLE_IN(en),
      .SUPPLY_LOW_IN(low), .BOOST_RISE_IN(boost), .CFG_OUT(cfg), .RAIL_EN_OUT(ren),
      .RESET_N_OUT(rst_n));
   task automatic ck(input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : ck
   task automatic cq(input logic [7:0] e[$]);
      foreach (e[k]) ck(e[k], r[k]);
   endtask : cq
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wt
   // main address write from index i, every byte acknowledged
   task automatic wr(input logic [7:0] i, input logic [7:0] d[$]);
      u_host.start();
      u_host.xb({ppic_pkg::MAIN_ADDR, 1'b0}, 1'b1, q, a);
      u_host.xb(i, 1'b1, q, a);
      foreach (d[k]) u_host.xb(d[k], 1'b1, q, a);
      ck(8'h00, {7'h00, a});
      u_host.stop();
   endtask : wr
   // index write, repeated start, n bytes, last one not acknowledged
   task automatic rd(input logic [7:0] i, input int n);
      r = {};
      u_host.start();
      u_host.xb({ppic_pkg::MAIN_ADDR, 1'b0}, 1'b1, q, a);
      u_host.xb(i, 1'b1, q, a);
      u_host.start();
      u_host.xb({ppic_pkg::MAIN_ADDR, 1'b1}, 1'b1, q, a);
      for (int k = 1; k <= n; k++) begin
         u_host.xb(8'hFF, k == n, q, a);
         r.push_back(q);
      end
      u_host.stop();
   endtask : rd
   task automatic t_dflt();
      rd(8'h06, 8);
      cq('{8'h0A, 8'h00, 8'h10, 8'h07, 8'h6E, 8'h02, 8'h02, 8'h06});
      rd(8'h12, 5);
      cq('{8'h45, 8'h45, 8'h01, 8'h07, 8'h05});
      ck(8'h02, {6'h00, cfg.core_slew});
      ck(8'h06, {3'h0, cfg.io_freq, cfg.io_slew});
      $display("t_dflt done");
   endtask : t_dflt
   task automatic t_burst();
      wr(8'h06, '{8'h29, 8'h2A, 8'h2B});
      rd(8'h06, 3);
      cq('{8'h29, 8'h00, 8'h2B});
      $display("t_burst done");
   endtask : t_burst
   task automatic t_store();
      wr(8'hFF, '{8'h01});
      rd(8'h08, 1);
      ck(8'h10, r[0]);
      wr(8'hFF, '{8'h81});
      rd(8'h08, 1);
      ck(8'h2B, r[0]);
      wr(8'h08, '{8'h33});
      wr(8'hFF, '{8'h00});
      rd(8'h08, 1);
      ck(8'h33, r[0]);
      $display("t_store done");
   endtask : t_store
   task automatic t_cal();
      u_host.start();
      u_host.xb({ppic_pkg::CAL_ADDR, 1'b0}, 1'b1, q, a);
      u_host.xb(8'hAB, 1'b1, q, a);
      u_host.start();
      u_host.xb({ppic_pkg::CAL_ADDR, 1'b1}, 1'b1, q, a);
      u_host.xb(8'hFF, 1'b1, q, a);
      ck(8'hAA, q);
      ck(8'h55, {1'b0, cfg.cal_level});
      u_host.start();
      u_host.xb(8'h22, 1'b1, q, a);
      u_host.stop();
      ck(8'h01, {7'h00, a});
      $display("t_cal done");
   endtask : t_cal
   task automatic t_cfg();
      for (int k = 0; k < 6; k++) begin
         wr(8'h12, '{{1'b0, k[1:0], k[2:0], 2'h0}});
         ck({k[1:0], k[2:0]}, {3'h0, cfg.core_slew, cfg.core_freq});
      end
      $display("t_cfg done");
   endtask : t_cfg
   task automatic t_seq();
      ok <= 1'b1;
      en <= 1'b1;
      boost <= 1'b1;
      wt(25);
      ck(8'h00, {7'h00, ren.io_buck});
      wt(15);
      ck(8'h01, {7'h00, ren.io_buck});
      wt(300);
      ck(8'h02, {6'h00, ren.common_electrode, rst_n});
      wt(60);
      ck(8'h01, {7'h00, rst_n});
      // working 12h was rewritten by t_cfg, the stored copy still holds 45h
      rd(8'h12, 1);
      ck(8'h45, r[0]);
      low <= 1'b1;
      wt(2);
      ck(8'h00, {7'h00, rst_n});
      // enable dropped while rails run, then a fresh start
      @(posedge sys_clk);
      en <= 1'b0;
      wt(2);
      ck(8'h00, {4'h0, ren});
      @(posedge sys_clk);
      en <= 1'b1;
      wt(40);
      ck(8'h01, {7'h00, ren.io_buck});
      @(posedge sys_clk);
      ok <= 1'b0;
      wt(2);
      ck(8'h00, {4'h0, ren});
      $display("t_seq done");
   endtask : t_seq
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   // main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      t_dflt();
      t_burst();
      t_store();
      t_cal();
      t_cfg();
      t_seq();
      test_done();
   end
   // watchdog well beyond the expected run
   initial begin
      #300000;
      n_mismatch++;
      test_done();
   end
endmodule : test_ppic_top
